// ==== shared/rtcm_pkg.sv ====
// Constants, field layout and shared types of the clock mode, flag and time save control block.
// Assumes a 50 MHz system clock and an AXI4-Lite master on the register side.
package rtcm_pkg;

  // ********************
  // Timing
  // ********************
  localparam int unsigned CLK_FREQ_MHZ       = 50;  // System clock rate
  localparam int unsigned LONG_DELAY_US      = 480; // Delayed lockout time
  localparam int unsigned SHORT_DELAY_US     = 30;  // Least short lockout time
  localparam int unsigned SHORT_DELAY_MAX_US = 63;  // Longest short lockout time
  localparam int unsigned LONG_DELAY_CYCLES  = LONG_DELAY_US * CLK_FREQ_MHZ; // Default
  localparam int unsigned SHORT_DELAY_CYCLES = SHORT_DELAY_US * CLK_FREQ_MHZ; // Shortest legal lockout
  localparam int          DELAY_CNT_W        = 16;  // Lockout counter width

  // ********************
  // Register byte addresses
  // ********************
  localparam logic [7:0] ADDR_FLAGS    = 8'h00; // periodic_rollover_flags
  localparam logic [7:0] ADDR_TS_CTRL  = 8'h04; // time_save_control
  localparam logic [7:0] ADDR_MODE     = 8'h08; // clock_mode_control
  localparam logic [7:0] ADDR_OUT_SEL  = 8'h0c; // output_select_control
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h10; // periodic_interrupt_enables
  localparam logic [7:0] ADDR_TEST     = 8'h14; // Test mode register
  localparam logic [7:0] ADDR_LOCK_STS = 8'h18; // Lockout status, read only

  // ********************
  // Field positions
  // ********************
  localparam int ROLL_N        = 6; // Rollover flags and enables
  localparam int FLAG_OSC_BIT  = 6; // Oscillator fail / single supply
  localparam int FLAG_TEST_BIT = 7; // Test register access
  localparam int TS_DELAY_BIT  = 5; // Power fail delay enable
  localparam int TS_LOWBAT_BIT = 6; // Low battery, read only
  localparam int TS_ENABLE_BIT = 7; // Time save enable
  localparam int OUT_MFO_BIT   = 7; // Multi-function output select
  localparam int TS_RAM_W      = 5; // Plain storage bits of time_save_control
  localparam int MODE_RUN_POS  = 3; // Clock start/stop

  // ********************
  // Reset values
  // ********************
  localparam logic [7:0] TS_CTRL_RESET = 8'h00;
  localparam logic [7:0] OUT_SEL_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET  = 8'h00;
  localparam logic [7:0] TEST_RESET    = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00; // Crystal bits are random on silicon; zero here

  // ********************
  // AXI responses
  // ********************
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ********************
  // Types
  // ********************
  typedef struct packed {
    logic crystal_select_high; // Oscillator frequency select
    logic crystal_select_low;
    logic ram5;                // Plain storage
    logic standby_irq_en;      // Interrupts stay alive in standby
    logic run;                 // Start/stop of prescaler and counters
    logic hour12;              // 12 hour mode with AM/PM
    logic leap_count_high;     // Years since last leap year
    logic leap_count_low;
  } rtcm_mode_s;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] dom;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtcm_time_s;

  typedef enum logic [1:0] {
    PF_IDLE       = 2'b00,
    PF_LONG_WAIT  = 2'b01,
    PF_SHORT_WAIT = 2'b10,
    PF_LOCKED     = 2'b11
  } rtcm_pf_state_e;

endpackage

// ==== hw/rtcm_core.sv ====
// Mode, flag, time save and lockout control of a real time clock.
// Assumes inputs synchronous to sys_clk_i and one AXI4-Lite access at a time.
`timescale 1ns/1ps

// Notes on behaviour
// - Low six flags set on rollover, clear on read
// - Flag bits line up with enable bits
// - Oscillator fail bit reads one after failure
// - Fail flag clears on start with running crystal
// - Writing bit six selects single or battery supply
// - Bit seven opens the test mode register
// - Delay enable keeps interface open 480 us
// - Clearing delay enable locks out at once
// - Without delay, lock out after 30-63 us
// - Low battery bit follows the comparator
// - Time save copies counters while enabled
// - Move to battery clears time save enable
// - Leap counter counts years, zero allows Feb 29
// - Bit two picks 12 or 24 hour counting
// - Start/stop runs or halts counter chain
// - Start/stop held low until oscillator runs
// - Standby without enable clears interrupt setup
// - Crystal select bits read back as written
// - Output register bit seven selects output source
// - Enabled rollovers raise the periodic interrupt
// - No enables means no periodic interrupt
// - Time save enable cleared on switch to battery
module rtcm_core
  import rtcm_pkg::*;
#(
  parameter int unsigned LONG_DELAY = LONG_DELAY_CYCLES // Shorten in simulation
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // AXI4-Lite slave
  input  wire logic [7:0]       s_axi_awaddr_i,
  input  wire logic             s_axi_awvalid_i,
  output logic                  s_axi_awready_o,
  input  wire logic [31:0]      s_axi_wdata_i,
  input  wire logic [3:0]       s_axi_wstrb_i,
  input  wire logic             s_axi_wvalid_i,
  output logic                  s_axi_wready_o,
  output logic [1:0]            s_axi_bresp_o,
  output logic                  s_axi_bvalid_o,
  input  wire logic             s_axi_bready_i,
  input  wire logic [7:0]       s_axi_araddr_i,
  input  wire logic             s_axi_arvalid_i,
  output logic                  s_axi_arready_o,
  output logic [31:0]           s_axi_rdata_o,
  output logic [1:0]            s_axi_rresp_o,
  output logic                  s_axi_rvalid_o,
  input  wire logic             s_axi_rready_i,
  // Clock chain and analog side
  input  wire logic [ROLL_N-1:0] rollover_i,        // Counter rollover pulses
  input  wire logic             year_end_i,         // December 31st rollover pulse
  input  wire logic             osc_fail_i,         // Oscillator fail event pulse
  input  wire logic             osc_running_i,      // Crystal oscillating correctly
  input  wire logic             power_fail_input_i, // High while main power has failed
  input  wire logic             on_battery_i,       // High while running from battery_supply_pin
  input  wire logic             low_battery_i,      // Battery comparator output
  input  wire rtcm_time_s       clock_time_i,       // Live clock counters
  // Control outputs
  output rtcm_mode_s            mode_o,             // Mode register fields
  output logic                  count_enable_o,     // Prescaler and counters run; low clears prescaler
  output logic                  feb29_allowed_o,    // Leap year counter at zero
  output logic                  single_supply_o,    // High disables oscillator reference
  output logic                  test_mode_o,        // Test register reachable
  output logic [7:0]            test_reg_o,         // Test mode register contents
  output logic                  mfo_select_o,       // Source select of multi_function_output
  output logic                  periodic_irq_o,     // Periodic interrupt request
  output logic                  host_locked_o,      // Host interface locked out
  output rtcm_time_s            time_save_o         // Time save storage
);

  // ********************
  // Register state
  // ********************
  logic [ROLL_N-1:0] roll_flags;     // Rollover flags
  logic              osc_failed;     // Oscillator fail indication
  logic [7:0]        ts_ctrl;        // time_save_control, bit 6 unused here
  rtcm_mode_s        mode;           // clock_mode_control
  logic [7:0]        out_sel;        // output_select_control
  logic [7:0]        irq_en;         // periodic_interrupt_enables
  rtcm_pf_state_e    pf_state;       // Lockout sequencer
  logic [DELAY_CNT_W-1:0] pf_cnt;    // Lockout delay counter
  logic              pf_q;           // Previous power fail level
  logic              bat_q;          // Previous battery level

  // ********************
  // Bus handshake state
  // ********************
  logic       aw_got;                // Write address held
  logic       w_got;                 // Write data held
  logic [7:0] wr_addr;               // Held write address
  logic [7:0] wr_data;               // Held low write byte
  logic       wr_lane0;              // Low byte lane enabled

  logic wr_fire;                     // Write performed this cycle
  logic rd_fire;                     // Read accepted this cycle
  logic pf_rise;                     // Power fail detected
  logic bat_rise;                    // Switch to battery supply
  logic wr_en;                       // Effective register write

  assign wr_fire  = aw_got && w_got && !s_axi_bvalid_o;
  assign rd_fire  = s_axi_arvalid_i && s_axi_arready_o;
  assign pf_rise  = power_fail_input_i && !pf_q;
  assign bat_rise = on_battery_i && !bat_q;
  // Lockout and a disabled byte lane both drop the write
  assign wr_en    = wr_fire && wr_lane0 && !host_locked_o;

  // ********************************************************************
  // Write channel handshake
  // ********************************************************************
  // Address and data taken in any order, one write in flight
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      wr_addr         <= 8'h00;
      wr_data         <= 8'h00;
      wr_lane0        <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got          <= 1'b1;
        wr_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got          <= 1'b1;
        wr_data        <= s_axi_wdata_i[7:0];
        wr_lane0       <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_got         <= 1'b0;
        w_got          <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Locked out or above ADDR_TEST answers an error
        if (host_locked_o || wr_addr > ADDR_TEST) begin
          s_axi_bresp_o <= RESP_SLVERR;
        end else begin
          s_axi_bresp_o <= RESP_OKAY;
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // ********************
  // Read channel
  // ********************
  // Data registered one cycle after the address is taken
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rresp_o   <= RESP_OKAY;
        s_axi_rdata_o   <= 32'h0000_0000;
        if (host_locked_o && s_axi_araddr_i != ADDR_LOCK_STS) begin
          // Reads other than lock status are refused once locked out
          s_axi_rresp_o <= RESP_SLVERR;
        end else begin
          case (s_axi_araddr_i)
            ADDR_FLAGS: begin
              s_axi_rdata_o[7:0] <= {test_mode_o, osc_failed, roll_flags};
            end
            ADDR_TS_CTRL: begin
              // Low battery taken live from the comparator
              s_axi_rdata_o[7:0] <= {ts_ctrl[TS_ENABLE_BIT], low_battery_i, ts_ctrl[TS_DELAY_BIT:0]};
            end
            ADDR_MODE: begin
              s_axi_rdata_o[7:0] <= mode;
            end
            ADDR_OUT_SEL: begin
              s_axi_rdata_o[7:0] <= out_sel;
            end
            ADDR_IRQ_EN: begin
              s_axi_rdata_o[7:0] <= irq_en;
            end
            ADDR_TEST: begin
              // Hidden unless the test bit is set
              if (test_mode_o) begin
                s_axi_rdata_o[7:0] <= test_reg_o;
              end
            end
            ADDR_LOCK_STS: begin
              s_axi_rdata_o[1:0] <= pf_state;
            end
            default: begin
              s_axi_rresp_o <= RESP_SLVERR;
            end
          endcase
        end
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Rollover flags
  // ********************************************************************
  // Per bit: a rollover in the read cycle survives the clear
  for (genvar i = 0; i < ROLL_N; i++) begin : g_flag
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        roll_flags[i] <= 1'b0;
      end else if (rollover_i[i]) begin
        roll_flags[i] <= 1'b1;
      end else if (bat_rise && !mode.standby_irq_en) begin
        roll_flags[i] <= 1'b0;
      end else if (rd_fire && !host_locked_o && s_axi_araddr_i == ADDR_FLAGS) begin
        roll_flags[i] <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Oscillator fail, supply mode, test access
  // ********************************************************************
  // Reset stands in for initial power-up; a fail event beats a clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_failed <= 1'b1;
    end else if (osc_fail_i) begin
      osc_failed <= 1'b1;
    end else if (wr_en && wr_addr == ADDR_MODE && wr_data[MODE_RUN_POS] && osc_running_i) begin
      osc_failed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      single_supply_o <= 1'b1;
      test_mode_o     <= 1'b0;
    end else begin
      if (osc_fail_i) begin
        single_supply_o <= 1'b1;
      end else if (wr_en && wr_addr == ADDR_FLAGS) begin
        single_supply_o <= wr_data[FLAG_OSC_BIT];
      end
      if (wr_en && wr_addr == ADDR_FLAGS) begin
        test_mode_o <= wr_data[FLAG_TEST_BIT];
      end
    end
  end

  // Test register only writable while test access is open
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_reg_o <= TEST_RESET;
    end else if (wr_en && wr_addr == ADDR_TEST && test_mode_o) begin
      test_reg_o <= wr_data;
    end
  end

  // ********************************************************************
  // Time save control and storage
  // ********************************************************************
  // Cleared on the move to battery, not on the fail input itself
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_ctrl <= TS_CTRL_RESET;
    end else if (bat_rise) begin
      ts_ctrl[TS_ENABLE_BIT] <= 1'b0;
    end else if (wr_en && wr_addr == ADDR_TS_CTRL) begin
      ts_ctrl[TS_ENABLE_BIT] <= wr_data[TS_ENABLE_BIT];
      ts_ctrl[TS_DELAY_BIT]  <= wr_data[TS_DELAY_BIT];
      ts_ctrl[TS_RAM_W-1:0]  <= wr_data[TS_RAM_W-1:0];
    end
  end

  // Follows the counters while enabled, frozen otherwise
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      time_save_o <= '0;
    end else if (ts_ctrl[TS_ENABLE_BIT]) begin
      time_save_o <= clock_time_i;
    end
  end

  // ********************************************************************
  // Clock mode register
  // ********************************************************************
  // Run bit stays low until the crystal is up and drops on a fail
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= MODE_RESET;
    end else begin
      if (wr_en && wr_addr == ADDR_MODE) begin
        mode <= wr_data;
      end else if (year_end_i) begin
        {mode.leap_count_high, mode.leap_count_low} <=
          2'({mode.leap_count_high, mode.leap_count_low} + 2'h1);
      end
      if (osc_fail_i || !osc_running_i) begin
        mode.run <= 1'b0;
      end
    end
  end

  // Registered copies for the counter chain
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o          <= MODE_RESET;
      count_enable_o  <= 1'b0;
      feb29_allowed_o <= 1'b1;
    end else begin
      mode_o          <= mode;
      count_enable_o  <= mode.run;
      feb29_allowed_o <= !mode.leap_count_high && !mode.leap_count_low;
    end
  end

  // ********************************************************************
  // Output select and periodic enables
  // ********************************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_sel <= OUT_SEL_RESET;
    end else if (wr_en && wr_addr == ADDR_OUT_SEL) begin
      out_sel <= wr_data;
    end
  end

  // Standby without the keep-alive bit wipes the enables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en <= IRQ_EN_RESET;
    end else if (bat_rise && !mode.standby_irq_en) begin
      irq_en <= IRQ_EN_RESET;
    end else if (wr_en && wr_addr == ADDR_IRQ_EN) begin
      irq_en <= wr_data;
    end
  end

  // Same bit positions pair flags with enables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      periodic_irq_o <= 1'b0;
      mfo_select_o   <= 1'b0;
    end else begin
      periodic_irq_o <= |(roll_flags & irq_en[ROLL_N-1:0]);
      mfo_select_o   <= out_sel[OUT_MFO_BIT];
    end
  end

  // ********************************************************************
  // Power fail lockout
  // ********************************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_q  <= 1'b0;
      bat_q <= 1'b0;
    end else begin
      pf_q  <= power_fail_input_i;
      bat_q <= on_battery_i;
    end
  end

  // Delay chosen at detection; returning power releases the lock
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_state      <= PF_IDLE;
      pf_cnt        <= '0;
      host_locked_o <= 1'b0;
    end else if (!power_fail_input_i) begin
      pf_state      <= PF_IDLE;
      pf_cnt        <= '0;
      host_locked_o <= 1'b0;
    end else begin
      case (pf_state)
        PF_IDLE: begin
          pf_cnt <= '0;
          if (pf_rise && ts_ctrl[TS_DELAY_BIT]) begin
            pf_state <= PF_LONG_WAIT;
          end else if (pf_rise) begin
            pf_state <= PF_SHORT_WAIT;
          end
        end
        PF_LONG_WAIT: begin
          pf_cnt <= pf_cnt + 1'b1;
          if (!ts_ctrl[TS_DELAY_BIT]) begin
            pf_state      <= PF_LOCKED;
            host_locked_o <= 1'b1;
          end else if (pf_cnt == DELAY_CNT_W'(LONG_DELAY - 1)) begin
            pf_state      <= PF_LOCKED;
            host_locked_o <= 1'b1;
          end
        end
        PF_SHORT_WAIT: begin
          pf_cnt <= pf_cnt + 1'b1;
          if (pf_cnt == DELAY_CNT_W'(SHORT_DELAY_CYCLES - 1)) begin
            pf_state      <= PF_LOCKED;
            host_locked_o <= 1'b1;
          end
        end
        PF_LOCKED: begin
          host_locked_o <= 1'b1;
        end
        default: begin
          pf_state <= PF_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== sim/rtcm_core_monitor.sv ====
// Checker of the rtcm_core control outputs, bound to every instance.
// Assumes one clock domain and the active high reset rst_i.
`timescale 1ns/1ps
module rtcm_core_monitor
  import rtcm_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       osc_fail_i,
  input wire logic       osc_running_i,
  input wire logic       power_fail_input_i,
  input wire logic       on_battery_i,
  input wire rtcm_mode_s mode_o,
  input wire logic       count_enable_o,
  input wire logic       feb29_allowed_o,
  input wire logic       single_supply_o,
  input wire logic       periodic_irq_o,
  input wire logic       host_locked_o,
  input wire rtcm_time_s time_save_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Standby entry: the saved time must hold still
  sequence s_frozen; $stable(time_save_o) [*4]; endsequence
  property p_cen; count_enable_o == mode_o.run; endproperty
  property p_leap; feb29_allowed_o == (mode_o[1:0] == 2'b00); endproperty
  property p_run; !osc_running_i |=> ##1 !count_enable_o; endproperty
  property p_ss; osc_fail_i |-> ##[1:2] single_supply_o; endproperty
  property p_rel; !power_fail_input_i |=> !host_locked_o; endproperty
  property p_hold; $rose(power_fail_input_i) |-> !host_locked_o [*8]; endproperty
  property p_sby; $rose(on_battery_i) && !mode_o.standby_irq_en |-> ##3 !periodic_irq_o [*3]; endproperty
  property p_save; $rose(on_battery_i) |-> ##3 s_frozen; endproperty
  a_cen: assert property (p_cen) else $error("count enable differs from run bit");
  a_leap: assert property (p_leap) else $error("feb29 permit wrong");
  a_run: assert property (p_run) else $error("counters run without oscillator");
  a_ss: assert property (p_ss) else $error("single supply not set on fail");
  a_rel: assert property (p_rel) else $error("lockout without power fail");
  a_hold: assert property (p_hold) else $error("lockout too early");
  a_sby: assert property (p_sby) else $error("periodic irq alive in standby");
  a_save: assert property (p_save) else $error("saved time not frozen");
endmodule
bind rtcm_core rtcm_core_monitor u_mon (.*);

// ==== sim/rtcm_host.sv ====
// Host model: AXI4-Lite master, one access at a time.
// Assumes its ports meet the register bus by name.
`timescale 1ns/1ps
module rtcm_host (
  input  wire logic        sys_clk_i,
  output logic [7:0]       s_axi_awaddr_i, s_axi_araddr_i,
  output logic [31:0]      s_axi_wdata_i,
  output logic [3:0]       s_axi_wstrb_i,
  output logic             s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i,
  input  wire logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o,
  input  wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o,
  input  wire logic [31:0] s_axi_rdata_o
);
  initial begin
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    s_axi_wstrb_i = 4'hf;
  end
  // Both channels offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o && n < 50);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (!s_axi_bvalid_o) testbench.hang();
  endtask
  // Address held until taken, rready held until rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o && n < 50);
    {r, d} = {s_axi_rresp_o, s_axi_rdata_o};
    s_axi_rready_i <= 1'b0;
    if (!s_axi_rvalid_o) testbench.hang();
  endtask
endmodule

// ==== sim/testbench.sv ====
// Testbench of rtcm_core: register traffic through the host model, clock-side pulses.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench
  import rtcm_pkg::*;
;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, year_end_i = 1'b0, osc_fail_i = 1'b0, osc_running_i = 1'b0;
  logic power_fail_input_i = 1'b0, on_battery_i = 1'b0, low_battery_i = 1'b0;
  logic [5:0] rollover_i = 6'h00;
  rtcm_time_s clock_time_i = '0;
  wire [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  wire [31:0] s_axi_wdata_i, s_axi_rdata_o;
  wire [3:0] s_axi_wstrb_i;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  wire s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  rtcm_mode_s mode_o;
  rtcm_time_s time_save_o;
  logic [7:0] test_reg_o;
  logic count_enable_o, feb29_allowed_o, single_supply_o, test_mode_o, mfo_select_o, periodic_irq_o, host_locked_o;
  int error_cnt = 0, check_count = 0;
  logic [31:0] rd_d;
  logic [1:0] rs;
  logic [7:0] ra [4] = '{ADDR_TS_CTRL, ADDR_MODE, ADDR_OUT_SEL, ADDR_IRQ_EN};
  rtcm_core #(.LONG_DELAY(40)) DUT (.*); // Short delay keeps the run brief
  rtcm_host host (.*);
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task automatic test_done;
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic hang; error_cnt++; test_done(); endtask
  task automatic cv(input logic [39:0] g, input logic [39:0] e);
    check_count++;
    if (g !== e) begin error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end
  endtask
  task automatic cb(input logic g, input logic e); cv({39'h0, g}, {39'h0, e}); endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    host.rd(a, rd_d, rs);
    cv({6'h0, rs, rd_d}, {6'h0, er, 24'h0, e});
  endtask
  task automatic wc(input logic [7:0] a, input logic [7:0] d); host.wr(a, d, rs); cv({38'h0, rs}, 40'h0); endtask
  task automatic cyc(input int n); repeat (n) @(posedge sys_clk_i); endtask
  task automatic pf(input logic v, input int n); power_fail_input_i <= v; cyc(n); endtask
  task automatic pulse(input logic [5:0] r); cyc(1); rollover_i <= r; cyc(1); rollover_i <= 6'h00; cyc(2); endtask
  // Lockout must appear within n cycles
  task automatic wlock(input int n);
    int k = 0;
    while (!host_locked_o && k < n) begin cyc(1); k++; end
    cb(host_locked_o, 1'b1);
    if (!host_locked_o) test_done();
  endtask
  initial begin cyc(100000); hang(); end
  initial begin
    cyc(12);
    rst_i <= 1'b0;
    rc(ADDR_FLAGS, 8'h40);
    foreach (ra[i]) rc(ra[i], 8'h00);
    rc(8'h1c, 8'h00, RESP_SLVERR);
    wc(ADDR_MODE, 8'h08);
    cyc(2);
    cb(count_enable_o, 1'b0);
    rc(ADDR_FLAGS, 8'h40);
    osc_running_i <= 1'b1;
    wc(ADDR_MODE, 8'h08);
    cyc(2);
    cb(count_enable_o, 1'b1);
    rc(ADDR_FLAGS, 8'h00);
    for (int i = 0; i < 4; i++) begin wc(ADDR_MODE, {i[1:0], 6'h0f}); rc(ADDR_MODE, {i[1:0], 6'h0f}); end
    cb(feb29_allowed_o, 1'b0);
    cyc(1); year_end_i <= 1'b1; cyc(1); year_end_i <= 1'b0; cyc(2);
    cb(feb29_allowed_o, 1'b1);
    rc(ADDR_MODE, 8'hcc);
    pulse(6'h3f);
    cb(periodic_irq_o, 1'b0);
    rc(ADDR_FLAGS, 8'h3f);
    rc(ADDR_FLAGS, 8'h00);
    wc(ADDR_IRQ_EN, 8'h04);
    pulse(6'h3b);
    cb(periodic_irq_o, 1'b0);
    pulse(6'h04);
    cb(periodic_irq_o, 1'b1);
    rc(ADDR_FLAGS, 8'h3f);
    cyc(2);
    cb(periodic_irq_o, 1'b0);
    wc(ADDR_FLAGS, 8'h3f);
    rc(ADDR_FLAGS, 8'h00);
    cb(single_supply_o, 1'b0);
    wc(ADDR_FLAGS, 8'h80); wc(ADDR_TEST, 8'h5a);
    cb(test_mode_o, 1'b1);
    rc(ADDR_TEST, 8'h5a);
    wc(ADDR_TEST, 8'h00); wc(ADDR_FLAGS, 8'h00); wc(ADDR_TEST, 8'h33);
    rc(ADDR_TEST, 8'h00);
    wc(ADDR_OUT_SEL, 8'h81); cyc(1);
    cb(mfo_select_o, 1'b1);
    rc(ADDR_OUT_SEL, 8'h81);
    low_battery_i <= 1'b1;
    rc(ADDR_TS_CTRL, 8'h40);
    low_battery_i <= 1'b0;
    wc(ADDR_TS_CTRL, 8'h80);
    clock_time_i <= 40'h0102030405; cyc(3);
    cv(time_save_o, 40'h0102030405);
    pulse(6'h04);
    on_battery_i <= 1'b1; cyc(3);
    clock_time_i <= 40'h0a0b0c0d0e; cyc(4);
    cv(time_save_o, 40'h0102030405);
    cb(periodic_irq_o, 1'b0);
    rc(ADDR_IRQ_EN, 8'h00);
    rc(ADDR_TS_CTRL, 8'h00);
    on_battery_i <= 1'b0;
    wc(ADDR_TS_CTRL, 8'h20);
    pf(1, 30);
    cb(host_locked_o, 1'b0);
    wlock(30);
    rc(ADDR_FLAGS, 8'h00, RESP_SLVERR);
    pf(0, 2);
    pf(1, 8);
    wc(ADDR_TS_CTRL, 8'h00);
    wlock(3);
    pf(0, 2);
    pf(1, 1400);
    cb(host_locked_o, 1'b0);
    wlock(1700);
    pf(0, 2);
    osc_fail_i <= 1'b1; cyc(1); osc_fail_i <= 1'b0; cyc(3);
    cb(single_supply_o, 1'b1);
    cb(count_enable_o, 1'b0);
    rc(ADDR_FLAGS, 8'h40);
    test_done();
  end
endmodule
